// [core/fss_cfg.svh]
// fixed figures of the fieldbus slave state machine
`ifndef FSS_CFG_SVH
`define FSS_CFG_SVH
`define FSS_TX_CHANNELS 4
`define FSS_RX_CHANNELS 4
`define FSS_MAP_MAX 16
`define FSS_MAP_IDX_HI 31
`define FSS_MAP_IDX_LO 16
`define FSS_MAP_SUB_HI 15
`define FSS_MAP_SUB_LO 8
`define FSS_MAP_LEN_HI 7
`define FSS_MAP_LEN_LO 0
`define FSS_LEN_8 8'h08
`define FSS_LEN_16 8'h10
`define FSS_LEN_32 8'h20
`define FSS_MODE_PP 8'h01
`define FSS_MODE_PV 8'h03
`define FSS_MODE_PT 8'h04
`define FSS_MODE_HM 8'h06
`define FSS_MODE_CSP 8'h08
`define FSS_MODE_CSV 8'h09
`define FSS_MODE_CST 8'h0a
`define FSS_MODE_RESET 8'h08
`define FSS_FIFO_DEPTH 16
`define FSS_ERR_NONE 3'h0
`define FSS_ERR_SKIP 3'h1
`define FSS_ERR_MAP_CNT 3'h2
`define FSS_ERR_MAP_LEN 3'h3
`define FSS_ERR_MODE 3'h4
`define FSS_ERR_SYNC 3'h5
`endif

// [core/fss_pkg.sv]
// types of the fieldbus slave state machine
`default_nettype none
package fss_pkg;
	typedef enum logic [1:0] {
		AL_INIT,
		AL_PREOP,
		AL_SAFEOP,
		AL_OP
	} fss_al_t;

	typedef enum logic [1:0] {
		SYNC_DC,
		SYNC_SM,
		SYNC_FREE
	} fss_sync_t;

	// one mapping entry write or commit from the mailbox side
	typedef struct packed {
		logic commit;
		logic dir_tx;
		logic [1:0] chan;
		logic [4:0] sub;
		logic [31:0] word;
	} fss_map_req_t;

	typedef struct packed {
		fss_al_t al;
		logic err;
		logic [2:0] err_code;
		logic [7:0] mode;
		logic [7:0][4:0] map_cnt;
		logic [31:0] rd_word;
		logic [31:0] tx_data;
		logic tx_valid;
		logic [31:0] mbx_data;
		logic mbx_valid;
		logic [1:0] s0_sync;
		logic s0_prev;
		logic tick;
		logic [1:0] lin_sync;
		logic [1:0] lout_sync;
		logic ring;
	} fss_state_t;
endpackage
`default_nettype wire

// [core/fss_top.sv]
// fieldbus slave state machine with process-data gating and receive buffer
// Behaviour
// - four transmit channels, sixteen objects each
// - four receive channels, sixteen objects each
// - seven supported drive operating modes
// - exactly four communication states
// - upward steps go strictly one at a time
// - downward from operational may skip states
// - init blocks all application traffic
// - pre-op serves mailbox, no process data
// - safe-op sends inputs, ignores received outputs
// - op passes mailbox and both process directions
// - process data cyclic, mailbox acyclic
// - in and out ports, line or ring
// - mapping word holds index, sub, length
// - only distributed-clock sync from sync0
`timescale 1ns/100ps
`include "fss_cfg.svh"
`default_nettype none

module fss_fifo #(
	parameter int W = 32,
	parameter int D = `FSS_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
		$error("fss_fifo depth must be a power of two");
	end
	if (W < 1) begin : g_w_chk
		$error("fss_fifo width must be at least one");
	end
	// extra pointer bit tells full from empty
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} fss_ptr_t;
	logic [W-1:0] mem [D];
	fss_ptr_t ptr_r;
	fss_ptr_t ptr_nxt;
	logic push;
	logic pop;

	assign in_ready = !((ptr_r.wp[AW] != ptr_r.rp[AW]) && (ptr_r.wp[AW-1:0] == ptr_r.rp[AW-1:0]));
	assign out_valid = (ptr_r.wp != ptr_r.rp);
	assign out_data = mem[ptr_r.rp[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		ptr_nxt = ptr_r;
		if (push) begin
			ptr_nxt.wp = ptr_r.wp + {{AW{1'b0}}, 1'b1};
		end
		if (pop) begin
			ptr_nxt.rp = ptr_r.rp + {{AW{1'b0}}, 1'b1};
		end
		// emptied outside op so stale commands never reach the drive
		if (flush) begin
			ptr_nxt = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ptr_r <= '0;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[ptr_r.wp[AW-1:0]] <= in_data;
		end
	end
endmodule

module fss_top #(
	parameter int MAP_MAX = `FSS_MAP_MAX,
	parameter int FIFO_DEPTH = `FSS_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	// state requests from the slave controller
	input wire logic al_req_valid,
	input wire fss_pkg::fss_al_t al_req_state,
	input wire fss_pkg::fss_sync_t sync_sel,
	output fss_pkg::fss_al_t al_state,
	output logic err_flag,
	output logic [2:0] err_code,
	input wire logic err_ack,
	// drive mode selection
	input wire logic mode_req_valid,
	input wire logic [7:0] mode_req,
	output logic [7:0] drive_mode,
	// mapping configuration
	input wire logic map_valid,
	input wire fss_pkg::fss_map_req_t map_req,
	input wire logic map_rd_tx,
	input wire logic [1:0] map_rd_chan,
	input wire logic [4:0] map_rd_sub,
	output logic [31:0] map_rd_word,
	output logic [4:0] map_rd_count,
	// mailbox path
	input wire logic mbx_in_valid,
	output logic mbx_in_ready,
	input wire logic [31:0] mbx_in_data,
	output logic mbx_out_valid,
	input wire logic mbx_out_ready,
	output logic [31:0] mbx_out_data,
	// receive process data toward the drive
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [31:0] rx_data,
	output logic drv_valid,
	input wire logic drv_ready,
	output logic [31:0] drv_data,
	// transmit process data from the drive
	input wire logic [31:0] app_tx_data,
	output logic tx_valid,
	output logic [31:0] tx_data,
	// pins
	input wire logic sync0_pin,
	input wire logic link_in_up,
	input wire logic link_out_up,
	output logic cycle_tick,
	output logic ring_topology
);
	localparam int CH = `FSS_TX_CHANNELS + `FSS_RX_CHANNELS;
	if (MAP_MAX < 1 || MAP_MAX > `FSS_MAP_MAX) begin : g_chk
		$error("fss_top MAP_MAX must lie in 1..16");
	end
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_fifo_chk
		$error("fss_top FIFO_DEPTH must be a power of two, at least 2");
	end

	fss_pkg::fss_state_t st_r;
	fss_pkg::fss_state_t st_nxt;
	logic [31:0] map_mem [CH][`FSS_MAP_MAX];
	logic [2:0] wr_ch;
	logic [2:0] rd_ch;
	logic map_wr_en;
	logic len_ok;
	logic mode_ok;
	logic in_op;
	logic pdo_in_on;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [31:0] fifo_out_data;

	assign wr_ch = {map_req.dir_tx, map_req.chan};
	assign rd_ch = {map_rd_tx, map_rd_chan};
	assign in_op = (st_r.al == fss_pkg::AL_OP);
	assign pdo_in_on = (st_r.al == fss_pkg::AL_SAFEOP) || in_op;

	always_comb begin
		unique case (map_req.word[`FSS_MAP_LEN_HI:`FSS_MAP_LEN_LO])
			`FSS_LEN_8, `FSS_LEN_16, `FSS_LEN_32: len_ok = 1'b1;
			default: len_ok = 1'b0;
		endcase
	end

	always_comb begin
		unique case (mode_req)
			`FSS_MODE_PP, `FSS_MODE_PV, `FSS_MODE_PT, `FSS_MODE_HM,
			`FSS_MODE_CSP, `FSS_MODE_CSV, `FSS_MODE_CST: mode_ok = 1'b1;
			default: mode_ok = 1'b0;
		endcase
	end

	// entries only change through the mailbox, so not while in init
	assign map_wr_en = map_valid && !map_req.commit && len_ok && (st_r.al != fss_pkg::AL_INIT)
		&& (map_req.sub != 5'h00) && (map_req.sub <= 5'(MAP_MAX));

	always_ff @(posedge core_clk) begin
		if (map_wr_en) begin
			map_mem[wr_ch][4'(map_req.sub - 5'h01)] <= map_req.word;
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;

		// pin inputs; first stage feeds only the second
		st_nxt.s0_sync = {st_r.s0_sync[0], sync0_pin};
		st_nxt.lin_sync = {st_r.lin_sync[0], link_in_up};
		st_nxt.lout_sync = {st_r.lout_sync[0], link_out_up};
		st_nxt.s0_prev = st_r.s0_sync[1];
		// ring only when both ports carry a link, else line end or chain
		st_nxt.ring = st_r.lin_sync[1] && st_r.lout_sync[1];

		// control cycle strictly from sync0 edges
		if (st_r.s0_sync[1] && !st_r.s0_prev && pdo_in_on) begin
			st_nxt.tick = 1'b1;
		end

		// inputs are captured once per bus cycle
		if (st_r.s0_sync[1] && !st_r.s0_prev && pdo_in_on) begin
			st_nxt.tx_data = app_tx_data;
			st_nxt.tx_valid = 1'b1;
		end else begin
			st_nxt.tx_valid = 1'b0;
		end

		// mailbox is a one-word stage, refused while in init
		if (st_r.mbx_valid && mbx_out_ready) begin
			st_nxt.mbx_valid = 1'b0;
		end
		if (mbx_in_valid && mbx_in_ready) begin
			st_nxt.mbx_data = mbx_in_data;
			st_nxt.mbx_valid = 1'b1;
		end
		if (st_r.al == fss_pkg::AL_INIT) begin
			st_nxt.mbx_valid = 1'b0;
		end

		// drive mode, kept when unsupported
		if (mode_req_valid && st_r.al != fss_pkg::AL_INIT) begin
			if (mode_ok) begin
				st_nxt.mode = mode_req;
			end
		end

		// mapping commit: count beyond the limit leaves the old count
		if (map_valid && map_req.commit && st_r.al == fss_pkg::AL_PREOP) begin
			if (map_req.sub <= 5'(MAP_MAX)) begin
				st_nxt.map_cnt[wr_ch] = map_req.sub;
			end
		end
		st_nxt.rd_word = map_mem[rd_ch][4'(map_rd_sub - 5'h01)];

		// state requests
		if (al_req_valid) begin
			if (al_req_state <= st_r.al) begin
				st_nxt.al = al_req_state;
			end else if (al_req_state == fss_pkg::fss_al_t'(2'(st_r.al + 2'h1))) begin
				if (al_req_state == fss_pkg::AL_SAFEOP && sync_sel != fss_pkg::SYNC_DC) begin
					st_nxt.al = st_r.al;
				end else begin
					st_nxt.al = al_req_state;
				end
			end
		end

		// error flag: acknowledge first so a new event in that cycle wins
		if (err_ack) begin
			st_nxt.err = 1'b0;
			st_nxt.err_code = `FSS_ERR_NONE;
		end
		if (al_req_valid && al_req_state > st_r.al
			&& al_req_state != fss_pkg::fss_al_t'(2'(st_r.al + 2'h1))) begin
			st_nxt.err = 1'b1;
			st_nxt.err_code = `FSS_ERR_SKIP;
		end else if (al_req_valid && al_req_state == fss_pkg::AL_SAFEOP && st_r.al == fss_pkg::AL_PREOP
			&& sync_sel != fss_pkg::SYNC_DC) begin
			st_nxt.err = 1'b1;
			st_nxt.err_code = `FSS_ERR_SYNC;
		end else if (map_valid && map_req.commit && st_r.al == fss_pkg::AL_PREOP
			&& map_req.sub > 5'(MAP_MAX)) begin
			st_nxt.err = 1'b1;
			st_nxt.err_code = `FSS_ERR_MAP_CNT;
		end else if (map_valid && !map_req.commit && st_r.al != fss_pkg::AL_INIT
			&& (!len_ok || map_req.sub == 5'h00 || map_req.sub > 5'(MAP_MAX))) begin
			st_nxt.err = 1'b1;
			st_nxt.err_code = `FSS_ERR_MAP_LEN;
		end else if (mode_req_valid && st_r.al != fss_pkg::AL_INIT && !mode_ok) begin
			st_nxt.err = 1'b1;
			st_nxt.err_code = `FSS_ERR_MODE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= '{
				al: fss_pkg::AL_INIT,
				err: 1'b0,
				err_code: `FSS_ERR_NONE,
				mode: `FSS_MODE_RESET,
				map_cnt: '0,
				rd_word: 32'h0000_0000,
				tx_data: 32'h0000_0000,
				tx_valid: 1'b0,
				mbx_data: 32'h0000_0000,
				mbx_valid: 1'b0,
				s0_sync: 2'h0,
				s0_prev: 1'b0,
				tick: 1'b0,
				lin_sync: 2'h0,
				lout_sync: 2'h0,
				ring: 1'b0
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	// received outputs: buffered only in op, accepted and dropped in safe-op
	fss_fifo #(
		.W(32),
		.D(FIFO_DEPTH)
	) u_rx_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.flush(!in_op),
		.in_valid(rx_valid && in_op),
		.in_ready(fifo_in_ready),
		.in_data(rx_data),
		.out_valid(fifo_out_valid),
		.out_ready(drv_ready && in_op),
		.out_data(fifo_out_data)
	);

	// outside op nothing is buffered; only safe-op swallows words, earlier states refuse
	assign rx_ready = in_op ? fifo_in_ready : (st_r.al == fss_pkg::AL_SAFEOP);
	assign drv_valid = fifo_out_valid && in_op;
	assign drv_data = fifo_out_data;
	assign mbx_in_ready = (st_r.al != fss_pkg::AL_INIT) && (!st_r.mbx_valid || mbx_out_ready);
	assign mbx_out_valid = st_r.mbx_valid;
	assign mbx_out_data = st_r.mbx_data;
	assign tx_valid = st_r.tx_valid;
	assign tx_data = st_r.tx_data;
	assign al_state = st_r.al;
	assign err_flag = st_r.err;
	assign err_code = st_r.err_code;
	assign drive_mode = st_r.mode;
	assign map_rd_word = st_r.rd_word;
	assign map_rd_count = st_r.map_cnt[rd_ch];
	assign cycle_tick = st_r.tick;
	assign ring_topology = st_r.ring;
endmodule

`default_nettype wire

// [tb/fss_sva.sv]
// port assertions for the fieldbus slave state machine
`timescale 1ns/100ps
`default_nettype none
module fss_sva (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic al_req_valid,
	input wire fss_pkg::fss_al_t al_req_state,
	input wire fss_pkg::fss_sync_t sync_sel,
	input wire fss_pkg::fss_al_t al_state,
	input wire logic err_flag,
	input wire logic [2:0] err_code,
	input wire logic mbx_in_ready,
	input wire logic rx_ready,
	input wire logic drv_valid,
	input wire logic tx_valid,
	input wire logic cycle_tick,
	input wire logic link_in_up,
	input wire logic link_out_up,
	input wire logic ring_topology
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_skip;
		al_req_valid && al_req_state > al_state + 3'd1 |=> al_state == $past(al_state) && err_flag && err_code == 3'h1;
	endproperty
	a_skip: assert property (p_skip) else $error("skip request not refused");
	property p_up;
		al_req_valid && al_req_state == al_state + 3'd1 && (al_state != fss_pkg::AL_PREOP || sync_sel == fss_pkg::SYNC_DC)
			|=> al_state == $past(al_req_state);
	endproperty
	a_up: assert property (p_up) else $error("single step up not taken");
	property p_down;
		al_req_valid && al_req_state <= al_state |=> al_state == $past(al_req_state);
	endproperty
	a_down: assert property (p_down) else $error("downward request not taken");
	property p_sync;
		al_req_valid && al_state == fss_pkg::AL_PREOP && al_req_state == fss_pkg::AL_SAFEOP && sync_sel != fss_pkg::SYNC_DC
			|=> al_state == fss_pkg::AL_PREOP && err_code == 3'h5;
	endproperty
	a_sync: assert property (p_sync) else $error("non dc sync accepted");
	property p_init;
		al_state == fss_pkg::AL_INIT |-> !mbx_in_ready && !rx_ready && !drv_valid;
	endproperty
	a_init: assert property (p_init) else $error("traffic in init");
	property p_preop;
		al_state == fss_pkg::AL_PREOP && $past(al_state) == fss_pkg::AL_PREOP |-> !rx_ready && !drv_valid && !tx_valid;
	endproperty
	a_preop: assert property (p_preop) else $error("process data in preop");
	property p_safe;
		al_state == fss_pkg::AL_SAFEOP |-> rx_ready && !drv_valid;
	endproperty
	a_safe: assert property (p_safe) else $error("outputs live in safeop");
	property p_tick;
		tx_valid |-> cycle_tick ##1 !tx_valid;
	endproperty
	a_tick: assert property (p_tick) else $error("tx pulse malformed");
	property p_ring;
		(link_in_up && link_out_up) [*6] |-> ring_topology;
	endproperty
	a_ring: assert property (p_ring) else $error("ring not seen");
	c_skip: cover property (al_req_valid && al_req_state > al_state + 3'd1);
	c_full: cover property (al_state == fss_pkg::AL_OP && !rx_ready);
	c_tx: cover property (tx_valid && al_state == fss_pkg::AL_SAFEOP);
endmodule
bind fss_top fss_sva i_sva (.core_clk, .sys_rst, .al_req_valid, .al_req_state, .sync_sel, .al_state, .err_flag,
	.err_code, .mbx_in_ready, .rx_ready, .drv_valid, .tx_valid, .cycle_tick, .link_in_up, .link_out_up, .ring_topology);
`default_nettype wire

// [tb/fss_master.sv]
// far-side master stand-in: output process data stream and sync0
`timescale 1ns/100ps
`default_nettype none
module fss_master (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic send,
	input wire logic rx_ready,
	output logic rx_valid,
	output logic [31:0] rx_data,
	output logic sync0_pin
);
	logic [31:0] n_r;
	logic [3:0] cyc_r;
	// idle data shows the inverse so a stale word cannot pass
	assign rx_data = rx_valid ? n_r : ~n_r;
	assign sync0_pin = cyc_r[3];
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			n_r <= 32'h0;
			cyc_r <= 4'h0;
		end else begin
			cyc_r <= cyc_r + 4'h1;
			if (rx_valid && rx_ready) begin
				n_r <= n_r + 32'h1;
			end
			if (!rx_valid || rx_ready) begin
				rx_valid <= send;
			end
		end
	end
endmodule
`default_nettype wire

// [tb/tb.sv]
// testbench for the fieldbus slave state machine
`timescale 1ns/100ps
`default_nettype none
module tb;
	typedef struct packed {
		fss_pkg::fss_al_t rq;
		fss_pkg::fss_sync_t sel;
		fss_pkg::fss_al_t st;
		logic [2:0] code;
	} fss_row_t;
	// request, sync source, then expected state and error code
	fss_row_t rows [9] = '{9'h181, 9'h101, 9'h089, 9'h12d, 9'h14d, 9'h189, 9'h111, 9'h199, 9'h001};
	logic [7:0] md [8] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h02};
	logic core_clk = 1'b0, sys_rst = 1'b1, al_req_valid = 1'b0, err_ack = 1'b0, mode_req_valid = 1'b0;
	logic map_valid = 1'b0, mbx_in_valid = 1'b0, drv_ready = 1'b0, link_in_up = 1'b0, link_out_up = 1'b0, send = 1'b0;
	logic map_rd_tx = 1'b1, mbx_out_ready = 1'b1;
	logic [1:0] map_rd_chan = 2'h0;
	logic [4:0] map_rd_sub = 5'h1;
	logic [7:0] mode_req = 8'h0;
	logic [31:0] mbx_in_data = 32'h0, app_tx_data = 32'h5a5a1234, first = 32'h0;
	fss_pkg::fss_al_t al_req_state = fss_pkg::AL_INIT;
	fss_pkg::fss_sync_t sync_sel = fss_pkg::SYNC_DC;
	fss_pkg::fss_map_req_t map_req = '0;
	fss_pkg::fss_al_t al_state;
	logic err_flag, mbx_in_ready, mbx_out_valid, rx_valid, rx_ready, drv_valid, tx_valid, sync0_pin, ring_topology;
	logic cycle_tick;
	logic [2:0] err_code;
	logic [4:0] map_rd_count;
	logic [7:0] drive_mode;
	logic [31:0] map_rd_word, mbx_out_data, rx_data, drv_data, tx_data;
	int fail_count = 0, checked = 0, pushes = 0;
	fss_top i_dut (.core_clk, .sys_rst, .al_req_valid, .al_req_state, .sync_sel, .al_state, .err_flag, .err_code,
		.err_ack, .mode_req_valid, .mode_req, .drive_mode, .map_valid, .map_req, .map_rd_tx, .map_rd_chan, .map_rd_sub,
		.map_rd_word, .map_rd_count, .mbx_in_valid, .mbx_in_ready, .mbx_in_data, .mbx_out_valid, .mbx_out_ready,
		.mbx_out_data, .rx_valid, .rx_ready, .rx_data, .drv_valid, .drv_ready, .drv_data, .app_tx_data, .tx_valid,
		.tx_data, .sync0_pin, .link_in_up, .link_out_up, .cycle_tick, .ring_topology);
	fss_master i_mst (.core_clk, .sys_rst, .send, .rx_ready, .rx_valid, .rx_data, .sync0_pin);
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (rx_valid && rx_ready && al_state == fss_pkg::AL_OP) begin
			if (pushes == 0) begin
				first = rx_data;
			end
			pushes++;
		end
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task results;
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task bound(input logic ok);
		if (ok !== 1'b1) begin
			fail_count++;
			results();
		end
	endtask
	task req(input fss_pkg::fss_al_t s);
		al_req_state <= s;
		al_req_valid <= 1'b1;
		tick(1);
		al_req_valid <= 1'b0;
		tick(1);
	endtask
	task map(input logic c, input logic [4:0] s, input logic [31:0] w);
		map_req <= '{c, map_rd_tx, 2'h0, s, w};
		map_valid <= 1'b1;
		tick(1);
		map_valid <= 1'b0;
		tick(1);
	endtask
	initial begin
		int n;
		int m;
		tick(12);
		sys_rst <= 1'b0;
		link_in_up <= 1'b1;
		link_out_up <= 1'b1;
		tick(1);
		for (int k = 0; k < 9; k++) begin
			sync_sel <= rows[k].sel;
			req(rows[k].rq);
			chk("state", al_state, rows[k].st);
			chk("code", err_code, rows[k].code);
		end
		chk("ring", ring_topology, 1);
		err_ack <= 1'b1;
		link_out_up <= 1'b0;
		tick(1);
		err_ack <= 1'b0;
		req(fss_pkg::AL_PREOP);
		chk("ack", err_flag, 0);
		for (int k = 0; k < 8; k++) begin
			mode_req <= md[k];
			mode_req_valid <= 1'b1;
			tick(1);
			mode_req_valid <= 1'b0;
			tick(1);
			chk("mode", drive_mode, k < 7 ? md[k] : 8'h0a);
		end
		chk("mode err", err_code, 4);
		chk("ring off", ring_topology, 0);
		map(1'b0, 5'h1, 32'h60410010);
		map(1'b0, 5'h3, 32'h60770018);
		chk("len err", err_code, 3);
		chk("word", map_rd_word, 32'h60410010);
		map(1'b1, 5'h11, 32'h0);
		chk("cnt err", err_code, 2);
		chk("cnt kept", map_rd_count, 0);
		map(1'b1, 5'h10, 32'h0);
		chk("cnt", map_rd_count, 16);
		map_rd_tx <= 1'b0;
		tick(1);
		map(1'b1, 5'h04, 32'h0);
		chk("rx cnt", map_rd_count, 4);
		mbx_in_data <= 32'hc0de0001;
		mbx_in_valid <= 1'b1;
		for (n = 0; n < 8; n++) begin
			tick(1);
			if (mbx_in_ready === 1'b1) break;
		end
		bound(mbx_in_ready);
		mbx_in_valid <= 1'b0;
		tick(1);
		chk("mbx", mbx_out_data, 32'hc0de0001);
		chk("mbx valid", mbx_out_valid, 1);
		req(fss_pkg::AL_SAFEOP);
		send <= 1'b1;
		for (n = 0; n < 40; n++) begin
			tick(1);
			if (tx_valid === 1'b1) break;
		end
		bound(tx_valid);
		chk("tx", tx_data, app_tx_data);
		chk("tick", cycle_tick, 1);
		req(fss_pkg::AL_OP);
		tick(40);
		chk("fill", pushes, 16);
		chk("full", rx_ready, 0);
		send <= 1'b0;
		drv_ready <= 1'b1;
		m = 0;
		for (n = 0; n < 24; n++) begin
			tick(1);
			if (drv_valid === 1'b1) begin
				chk("drv", drv_data, first + m);
				m++;
			end
		end
		chk("drained", m, 17);
		sys_rst <= 1'b1;
		tick(2);
		sys_rst <= 1'b0;
		tick(1);
		chk("rst state", al_state, 0);
		chk("rst mode", drive_mode, 8'h08);
		chk("rst err", err_flag, 0);
		chk("rst cnt", map_rd_count, 0);
		results();
	end
endmodule
`default_nettype wire
